// *** bench/mdu_checker_sva.sv ***
`default_nettype none
module muldiv_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic busy,
   input wire logic results_pending
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Counts busy cycles so the length check needs no long repetition.
   logic [4:0] run_reg;
   logic [4:0] run_next;
   always_comb begin
      run_next = busy ? run_reg + 5'h01 : 5'h00;
   end
   always_ff @(posedge mclk) begin
      run_reg <= sys_rst ? 5'h00 : run_next;
   end
   start_src_a: assert property ($rose(busy) |-> $past(reg_wr) && $past(reg_sel) == 3'h5)
      else $error("busy rose without a final byte 5 write");
   busy_len_a: assert property ($fell(busy) |-> run_reg inside {5'h09, 5'h0B, 5'h11})
      else $error("calculation length wrong");
   done_pend_a: assert property ($fell(busy) |-> results_pending)
      else $error("no pending results at completion");
   pend_src_a: assert property ($rose(results_pending) |-> $fell(busy))
      else $error("pending rose without completion");
   busy_rd_a: assert property (busy && reg_rd && reg_sel < 3'h6 |=> reg_rdata == 8'h00)
      else $error("byte read while busy returned data");
   err_seen_a: assert property (busy && reg_rd && reg_sel < 3'h6 ##2 busy && reg_rd && reg_sel == 3'h6
      |=> reg_rdata[7])
      else $error("error flag missing");
   stat_pad_a: assert property (reg_rd && reg_sel == 3'h6 |=> reg_rdata[5:0] == 6'h00)
      else $error("status low bits not zero");
   hold_rd_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   cover property ($fell(busy) && run_reg == 5'h11);
   cover property ($fell(busy) && run_reg == 5'h09);
   cover property ($fell(busy) && run_reg == 5'h0B);
endmodule : muldiv_checker
bind mult_div_unit muldiv_checker chk (.mclk(mclk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .busy(busy), .results_pending(results_pending));
`default_nettype wire

// *** bench/mult_div_unit_sequencer_test.sv ***
`default_nettype none
module mult_div_unit_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] reg_sel = 3'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic busy;
   logic results_pending;
   logic [7:0] q;
   int errors = 0;
   int tests_run = 0;
   always #2 mclk = ~mclk;
   mult_div_unit dut (.mclk(mclk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .busy(busy), .results_pending(results_pending));
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic access(input logic w, input logic [2:0] s, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = w;
      reg_rd = !w;
      reg_sel = s;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      q = reg_rdata;
   endtask : access
   task automatic put(input logic [2:0] s, input logic [31:0] a, input logic [15:0] b);
      access(1'b1, s, s[2] ? b[8*s[0] +: 8] : a[8*s[1:0] +: 8]);
   endtask : put
   task automatic take(input logic [2:0] s, input logic [7:0] e);
      access(1'b0, s, 8'h00);
      check(q, e, "read");
   endtask : take
   task automatic measure(input int n);
      int c;
      c = 0;
      while (busy === 1'b1 && c < 40) begin
         c++;
         @(negedge mclk);
      end
      check(8'(c), 8'(n), "busy length");
      check({7'h00, results_pending}, 8'h01, "pending");
   endtask : measure
   task automatic t_div32();
      logic [47:0] r;
      r = {16'(32'hFEDCBA98 % 16'h0123), 32'hFEDCBA98 / 16'h0123};
      for (int s = 0; s < 6; s++) put(3'(s), 32'hFEDCBA98, 16'h0123);
      measure(17);
      take(3'h6, 8'h00);
      for (int s = 0; s < 6; s++) take(3'(s), r[8*s +: 8]);
      @(negedge mclk);
      check({7'h00, results_pending}, 8'h00, "pending");
      $display("div32 finished");
   endtask : t_div32
   task automatic t_div16_zero();
      put(3'h0, 32'h00008765, 16'h0000);
      put(3'h1, 32'h00008765, 16'h0000);
      take(3'h6, 8'h00);
      put(3'h4, 32'h00008765, 16'h0000);
      put(3'h5, 32'h00008765, 16'h0000);
      measure(9);
      take(3'h6, 8'h40);
      take(3'h0, 8'hFF);
      take(3'h1, 8'hFF);
      take(3'h4, 8'h65);
      take(3'h5, 8'h87);
      check({7'h00, results_pending}, 8'h00, "pending");
      $display("div16 finished");
   endtask : t_div16_zero
   task automatic t_mul();
      logic [31:0] p;
      p = 32'h0000ABCD * 32'h00001234;
      put(3'h0, 32'h0000ABCD, 16'h1234);
      put(3'h4, 32'h0000ABCD, 16'h1234);
      put(3'h1, 32'h0000ABCD, 16'h1234);
      put(3'h5, 32'h0000ABCD, 16'h1234);
      measure(11);
      take(3'h6, 8'h40);
      // An early out-of-order read must not advance the read tracking.
      take(3'h1, p[15:8]);
      for (int s = 0; s < 4; s++) take(3'(s), p[8*s +: 8]);
      @(negedge mclk);
      check({7'h00, results_pending}, 8'h00, "pending");
      $display("multiply finished");
   endtask : t_mul
   task automatic t_bad_order();
      put(3'h0, 32'h01020304, 16'h0506);
      put(3'h1, 32'h01020304, 16'h0506);
      put(3'h2, 32'h01020304, 16'h0506);
      put(3'h5, 32'h01020304, 16'h0506);
      check({7'h00, busy}, 8'h00, "busy");
      $display("bad order finished");
   endtask : t_bad_order
   task automatic t_busy_access();
      int c;
      c = 0;
      put(3'h0, 32'h00000010, 16'h0020);
      put(3'h4, 32'h00000010, 16'h0020);
      put(3'h1, 32'h00000010, 16'h0020);
      put(3'h5, 32'h00000010, 16'h0020);
      take(3'h0, 8'h00);
      take(3'h6, 8'hC0);
      while (busy === 1'b1 && c < 40) begin
         c++;
         @(negedge mclk);
      end
      take(3'h6, 8'h80);
      take(3'h6, 8'h00);
      take(3'h1, 8'h02);
      $display("busy access finished");
   endtask : t_busy_access
   task automatic close_out();
      $display("%0d checks, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   initial begin
      #20000;
      errors++;
      close_out();
   end
   initial begin
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      t_div32();
      t_div16_zero();
      t_mul();
      t_bad_order();
      t_busy_access();
      close_out();
   end
endmodule : mult_div_unit_sequencer_test
`default_nettype wire

// *** src/mdu_arith_core.sv ***
`default_nettype none
module muldiv_arith_core (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic start,
   input wire muldiv_pkg::op_e op,
   input wire logic [31:0] operand_a,
   input wire logic [15:0] operand_b,
   output logic [47:0] result,
   output logic overflow
);
   logic [47:0] result_reg;
   logic [47:0] result_next;
   logic overflow_reg;
   logic overflow_next;
   logic [31:0] product;

   always_comb begin
      product = operand_a[15:0] * operand_b;
      result_next = result_reg;
      overflow_next = overflow_reg;
      if (start) begin
         unique case (op)
            muldiv_pkg::OP_MUL: begin
               result_next = {16'h0000, product};
               overflow_next = (product > {16'h0000, muldiv_pkg::PRODUCT_LIMIT});
            end
            muldiv_pkg::OP_DIV32, muldiv_pkg::OP_DIV16: begin
               if (operand_b == 16'h0000) begin
                  // A zero divisor gives an all-ones quotient and returns the dividend low word.
                  result_next = {operand_a[15:0], 32'hFFFFFFFF};
                  overflow_next = 1'b1;
               end else begin
                  result_next = {16'(operand_a % {16'h0000, operand_b}), operand_a / {16'h0000, operand_b}};
                  overflow_next = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         result_reg <= 48'h000000000000;
         overflow_reg <= 1'b0;
      end else begin
         result_reg <= result_next;
         overflow_reg <= overflow_next;
      end
   end

   assign result = result_reg;
   assign overflow = overflow_reg;
endmodule : muldiv_arith_core
`default_nettype wire

// *** src/mdu_pkg.sv ***
`default_nettype none
package muldiv_pkg;
   // Register selects on the CPU side port.
   localparam logic [2:0] SEL_BYTE0 = 3'h0;
   localparam logic [2:0] SEL_BYTE1 = 3'h1;
   localparam logic [2:0] SEL_BYTE2 = 3'h2;
   localparam logic [2:0] SEL_BYTE3 = 3'h3;
   localparam logic [2:0] SEL_BYTE4 = 3'h4;
   localparam logic [2:0] SEL_BYTE5 = 3'h5;
   localparam logic [2:0] SEL_STATUS = 3'h6;
   localparam int NUM_BYTES = 6;
   // Status register layout and reset value.
   localparam int STAT_ERR_BIT = 7;
   localparam int STAT_OVF_BIT = 6;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Calculation times in system clock periods.
   localparam int CYC_DIV32 = 17;
   localparam int CYC_DIV16 = 9;
   localparam int CYC_MUL = 11;
   localparam logic [4:0] CNT_DIV32 = 5'(CYC_DIV32 - 1);
   localparam logic [4:0] CNT_DIV16 = 5'(CYC_DIV16 - 1);
   localparam logic [4:0] CNT_MUL = 5'(CYC_MUL - 1);
   // Index of the last result byte in the read order.
   localparam logic [2:0] LAST_RD_DIV = 3'h5;
   localparam logic [2:0] LAST_RD_MUL = 3'h3;
   localparam logic [15:0] PRODUCT_LIMIT = 16'hFFFF;
   typedef enum logic [1:0] {OP_DIV32, OP_DIV16, OP_MUL} op_e;
endpackage : muldiv_pkg
`default_nettype wire

// *** src/mult_div_unit.sv ***
`default_nettype none
// What this block does
// - 32/16 divide takes dividend bytes via bytes 0-3, then divisor via 4, 5.
// - 16/16 divide takes writes in order byte 0, 1, 4, 5.
// - 16x16 multiply takes writes in order byte 0, 4, 1, 5.
// - Calculation lasts 17, 9 or 11 clocks for div32, div16, multiply.
// - Div32 results: quotient in bytes 0-3, remainder in bytes 4-5.
// - Div16 results: quotient in bytes 0-1, remainder in bytes 4-5.
// - Multiply result: product bytes 0-3 in bytes 0-3.
// - Read order is tracked; unrelated cycles between reads do no harm.
// - On completion, results replace the operands in the byte registers.
// - Only a write of byte 5 ending a valid order starts work.
// - Byte access while busy sets error flag; status read after completion clears it.
// - Overflow flag updates at completion: product above FFFF or zero divisor.
module mult_div_unit (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic busy,
   output logic results_pending
);
   typedef enum logic [3:0] {
      SEQ_NONE, SEQ_B0, SEQ_DIV_B1, SEQ_D32_B2, SEQ_D32_B3, SEQ_D32_B4,
      SEQ_D16_B4, SEQ_MUL_B4, SEQ_MUL_B1
   } seq_e;

   logic [5:0][7:0] data_reg;
   logic [5:0][7:0] data_next;
   seq_e seq_reg;
   seq_e seq_next;
   logic busy_reg;
   logic busy_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   muldiv_pkg::op_e op_reg;
   muldiv_pkg::op_e op_next;
   logic err_reg;
   logic err_next;
   logic ovf_reg;
   logic ovf_next;
   logic [2:0] rd_idx_reg;
   logic [2:0] rd_idx_next;
   logic pending_reg;
   logic pending_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic data_sel;
   logic wr_ok;
   logic start;
   logic done;
   muldiv_pkg::op_e start_op;
   logic [31:0] operand_a;
   logic [15:0] operand_b;
   logic [47:0] core_result;
   logic core_ovf;

   // Advances the write order tracker by one accepted byte write.
   function automatic seq_e seq_step(input seq_e cur, input logic [2:0] idx);
      seq_e nxt;
      nxt = SEQ_NONE;
      unique case (cur)
         SEQ_B0: begin
            if (idx == muldiv_pkg::SEL_BYTE1) nxt = SEQ_DIV_B1;
            else if (idx == muldiv_pkg::SEL_BYTE4) nxt = SEQ_MUL_B4;
         end
         SEQ_DIV_B1: begin
            if (idx == muldiv_pkg::SEL_BYTE2) nxt = SEQ_D32_B2;
            else if (idx == muldiv_pkg::SEL_BYTE4) nxt = SEQ_D16_B4;
         end
         SEQ_D32_B2: begin
            if (idx == muldiv_pkg::SEL_BYTE3) nxt = SEQ_D32_B3;
         end
         SEQ_D32_B3: begin
            if (idx == muldiv_pkg::SEL_BYTE4) nxt = SEQ_D32_B4;
         end
         SEQ_MUL_B4: begin
            if (idx == muldiv_pkg::SEL_BYTE1) nxt = SEQ_MUL_B1;
         end
         SEQ_NONE, SEQ_D32_B4, SEQ_D16_B4, SEQ_MUL_B1: nxt = SEQ_NONE;
      endcase
      // A stray write to byte 0 always opens a fresh order.
      if (nxt == SEQ_NONE && idx == muldiv_pkg::SEL_BYTE0) nxt = SEQ_B0;
      return nxt;
   endfunction : seq_step

   assign data_sel = (reg_sel <= muldiv_pkg::SEL_BYTE5);
   assign wr_ok = reg_wr && data_sel && !busy_reg;

   // Start decode; other interleaved cycles leave the tracker untouched.
   always_comb begin
      start = 1'b0;
      start_op = muldiv_pkg::OP_DIV32;
      if (wr_ok && reg_sel == muldiv_pkg::SEL_BYTE5) begin
         unique case (seq_reg)
            SEQ_D32_B4: begin
               start = 1'b1;
               start_op = muldiv_pkg::OP_DIV32;
            end
            SEQ_D16_B4: begin
               start = 1'b1;
               start_op = muldiv_pkg::OP_DIV16;
            end
            SEQ_MUL_B1: begin
               start = 1'b1;
               start_op = muldiv_pkg::OP_MUL;
            end
            default: start = 1'b0;
         endcase
      end
   end

   // Operands are gathered here; byte 5 comes straight from the bus as it is being written.
   always_comb begin
      operand_a = {16'h0000, data_reg[1], data_reg[0]};
      if (start_op == muldiv_pkg::OP_DIV32) begin
         operand_a = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
      end
      operand_b = {reg_wdata, data_reg[4]};
   end

   muldiv_arith_core u_core (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .start(start),
      .op(start_op),
      .operand_a(operand_a),
      .operand_b(operand_b),
      .result(core_result),
      .overflow(core_ovf)
   );

   assign done = busy_reg && (cnt_reg == 5'h00);

   always_comb begin
      data_next = data_reg;
      seq_next = seq_reg;
      busy_next = busy_reg;
      cnt_next = cnt_reg;
      op_next = op_reg;
      err_next = err_reg;
      ovf_next = ovf_reg;
      rd_idx_next = rd_idx_reg;
      pending_next = pending_reg;
      rdata_next = rdata_reg;
      if (wr_ok) begin
         data_next[reg_sel] = reg_wdata;
         seq_next = start ? SEQ_NONE : seq_step(seq_reg, reg_sel);
      end
      if (start) begin
         busy_next = 1'b1;
         op_next = start_op;
         pending_next = 1'b0;
         unique case (start_op)
            muldiv_pkg::OP_DIV32: cnt_next = muldiv_pkg::CNT_DIV32;
            muldiv_pkg::OP_DIV16: cnt_next = muldiv_pkg::CNT_DIV16;
            muldiv_pkg::OP_MUL: cnt_next = muldiv_pkg::CNT_MUL;
         endcase
      end else if (busy_reg) begin
         cnt_next = cnt_reg - 5'h01;
      end
      if (done) begin
         busy_next = 1'b0;
         ovf_next = core_ovf;
         rd_idx_next = muldiv_pkg::SEL_BYTE0;
         pending_next = 1'b1;
         for (int i = 0; i < muldiv_pkg::NUM_BYTES; i++) begin
            data_next[i] = core_result[8 * i +: 8];
         end
      end
      if (reg_rd) begin
         if (reg_sel == muldiv_pkg::SEL_STATUS) begin
            rdata_next = muldiv_pkg::STAT_RESET;
            rdata_next[muldiv_pkg::STAT_ERR_BIT] = err_reg;
            rdata_next[muldiv_pkg::STAT_OVF_BIT] = ovf_reg;
            if (!busy_reg) err_next = 1'b0;
         end else if (data_sel) begin
            // Reads during a calculation return zero rather than half-built state.
            rdata_next = busy_reg ? 8'h00 : data_reg[reg_sel];
            if (!busy_reg && pending_reg && reg_sel == rd_idx_reg) begin
               if (reg_sel == ((op_reg == muldiv_pkg::OP_MUL) ? muldiv_pkg::LAST_RD_MUL : muldiv_pkg::LAST_RD_DIV)) begin
                  pending_next = 1'b0;
               end else if (op_reg == muldiv_pkg::OP_DIV16 && reg_sel == muldiv_pkg::SEL_BYTE1) begin
                  rd_idx_next = muldiv_pkg::SEL_BYTE4;
               end else begin
                  rd_idx_next = rd_idx_reg + 3'h1;
               end
            end
         end else begin
            rdata_next = 8'h00;
         end
      end
      // The set is placed last so that it wins over a clear in the same cycle.
      if (busy_reg && data_sel && (reg_wr || reg_rd)) err_next = 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         data_reg <= {muldiv_pkg::NUM_BYTES{muldiv_pkg::BYTE_RESET}};
         seq_reg <= SEQ_NONE;
         busy_reg <= 1'b0;
         cnt_reg <= 5'h00;
         op_reg <= muldiv_pkg::OP_DIV32;
         err_reg <= 1'b0;
         ovf_reg <= 1'b0;
         rd_idx_reg <= 3'h0;
         pending_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         data_reg <= data_next;
         seq_reg <= seq_next;
         busy_reg <= busy_next;
         cnt_reg <= cnt_next;
         op_reg <= op_next;
         err_reg <= err_next;
         ovf_reg <= ovf_next;
         rd_idx_reg <= rd_idx_next;
         pending_reg <= pending_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign busy = busy_reg;
   assign results_pending = pending_reg;
endmodule : mult_div_unit
`default_nettype wire
